/* File: hdl/fsps_defines.svh */
`ifndef FSPS_DEFINES_SVH
`define FSPS_DEFINES_SVH
`define FSPS_REG_CTRL    2'h0
`define FSPS_REG_PTR     2'h1
`define FSPS_REG_DATA    2'h2
`define FSPS_REG_STAT    2'h3
`define FSPS_CMD_CLEAR   5'h11
`define FSPS_CMD_FUSE    5'h09
`define FSPS_CMD_WRITE   5'h05
`define FSPS_CMD_ERASE   5'h03
`define FSPS_CMD_LOAD    5'h01
`define FSPS_STORE_WIN   3'h4
`define FSPS_LOAD_WIN    3'h3
`define FSPS_WORD_BITS   5
`define FSPS_PAGE_BITS   3
`define FSPS_CLK_MHZ     200
`define FSPS_OP_MIN_MS   3.7
`define FSPS_OP_MAX_MS   4.5
`define FSPS_PTR_FUSE_LO 16'h0000
`define FSPS_PTR_LOCK    16'h0001
`define FSPS_PTR_FUSE_HI 16'h0003
`define FSPS_ERASED      16'hFFFF
`define FSPS_LOCK_PAD    6'h3F
`define FSPS_UNMAPPED    8'hFF
`endif

/* File: hdl/fsps_pkg.sv */
package fsps_pkg;
  typedef struct packed {
    logic clr_page;
    logic fuse_read;
    logic pgwr;
    logic pger;
    logic en;
  } fsps_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_WRITE = 3'b100
  } fsps_state_t;
endpackage

/* File: hdl/fsps_sequencer.sv */
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "fsps_defines.svh"

module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int WORD_BITS = `FSPS_WORD_BITS,
  parameter int OP_CYCLES = int'(`FSPS_OP_MIN_MS * 1000.0 * `FSPS_CLK_MHZ)
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [1:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        store_op_in,
  input  wire logic        load_op_in,
  input  wire logic        eeprom_busy_in,
  input  wire logic        eeprom_write_in,
  input  wire logic [7:0]  fuse_low_in,
  input  wire logic [7:0]  fuse_high_in,
  input  wire logic [1:0]  lock_bits_in,
  output logic      [7:0]  load_data_out,
  output logic             load_valid_out,
  output logic             stall_out
);
  localparam int PB      = `FSPS_PAGE_BITS;
  localparam int AW      = PB + WORD_BITS;
  localparam int NW      = 1 << WORD_BITS;
  localparam int OP_MAX  = int'($floor(`FSPS_OP_MAX_MS * 1000.0 * `FSPS_CLK_MHZ));
  localparam logic [2:0] LOAD_LAST = `FSPS_STORE_WIN - `FSPS_LOAD_WIN + 3'h1;

  logic [15:0]       ptr_q;
  logic [15:0]       data_q;
  fsps_ctrl_t        ctrl_q;
  logic [2:0]        win_q;
  fsps_state_t       state_q;
  logic [19:0]       op_cnt_q;
  logic [PB-1:0]     page_q;
  logic              stall_q;
  logic [15:0]       rdata_q;
  logic [7:0]        load_data_q;
  logic              load_valid_q;
  logic [15:0]       buf_q [NW];
  logic [15:0]       flash_q [1 << AW];

  logic              ctrl_wr;
  logic [4:0]        cmd;
  logic              cmd_ok;
  logic              arm;
  logic              store_go;
  logic              do_load;
  logic              do_erase;
  logic              do_write;
  logic              fuse_rd;
  logic              op_done;
  logic              clr_buf;
  logic [WORD_BITS-1:0] pg_word;
  logic [PB-1:0]     pg_page;
  logic [15:0]       rd_word;

  assign ctrl_wr = reg_wr_in && (reg_addr_in == `FSPS_REG_CTRL);
  assign cmd     = reg_wdata_in[4:0];
  assign cmd_ok  = (cmd == `FSPS_CMD_CLEAR) || (cmd == `FSPS_CMD_FUSE) || (cmd == `FSPS_CMD_WRITE) ||
                   (cmd == `FSPS_CMD_ERASE) || (cmd == `FSPS_CMD_LOAD);
  // eeprom busy refuses control writes; a store command armed before it still runs
  assign arm      = ctrl_wr && cmd_ok && !eeprom_busy_in && (state_q == ST_IDLE);
  assign store_go = store_op_in && ctrl_q.en && (win_q != 3'h0) && (state_q == ST_IDLE);
  assign do_load  = store_go && (ctrl_q == `FSPS_CMD_LOAD);
  assign do_erase = store_go && (ctrl_q == `FSPS_CMD_ERASE);
  assign do_write = store_go && (ctrl_q == `FSPS_CMD_WRITE);
  // a blocked fuse read falls through to an ordinary flash byte
  assign fuse_rd  = load_op_in && (ctrl_q == `FSPS_CMD_FUSE) && (win_q >= LOAD_LAST) && !eeprom_busy_in;
  assign op_done  = (state_q != ST_IDLE) && (op_cnt_q == 20'(OP_CYCLES - 1));
  // bit 0 picks the byte, so store-program ignores it
  assign pg_word  = ptr_q[WORD_BITS:1];
  assign pg_page  = ptr_q[AW:WORD_BITS+1];
  assign clr_buf  = (arm && (cmd == `FSPS_CMD_CLEAR)) || (op_done && (state_q == ST_WRITE)) ||
                    eeprom_write_in;
  assign rd_word  = flash_q[ptr_q[AW:1]];

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_q  <= 16'h0000;
      data_q <= 16'h0000;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `FSPS_REG_PTR) begin
        ptr_q <= reg_wdata_in;
      end
      if (reg_addr_in == `FSPS_REG_DATA) begin
        data_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `FSPS_REG_CTRL: rdata_q <= {11'h000, ctrl_q};
        `FSPS_REG_PTR:  rdata_q <= ptr_q;
        `FSPS_REG_DATA: rdata_q <= data_q;
        `FSPS_REG_STAT: rdata_q <= {14'h0000, eeprom_busy_in, stall_q};
        default:        rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // control bits and the arming window
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= '0;
      win_q  <= 3'h0;
    end else if (arm) begin
      ctrl_q <= cmd;
      win_q  <= `FSPS_STORE_WIN;
    end else if (op_done) begin
      ctrl_q <= '0;
      win_q  <= 3'h0;
    end else if (state_q != ST_IDLE || do_erase || do_write) begin
      // enable stays high until the operation ends
      ctrl_q <= ctrl_q;
    end else if (store_go || fuse_rd || win_q == 3'h1 || (ctrl_q.fuse_read && win_q == LOAD_LAST)) begin
      ctrl_q <= '0;
      win_q  <= 3'h0;
    end else if (win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q  <= ST_IDLE;
      op_cnt_q <= 20'h00000;
      page_q   <= '0;
      stall_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          op_cnt_q <= 20'h00000;
          if (do_erase) begin
            state_q <= ST_ERASE;
            page_q  <= pg_page;
            stall_q <= 1'b1;
          end else if (do_write) begin
            state_q <= ST_WRITE;
            page_q  <= pg_page;
            stall_q <= 1'b1;
          end
        end
        ST_ERASE, ST_WRITE: begin
          op_cnt_q <= op_cnt_q + 20'h00001;
          if (op_done) begin
            state_q <= ST_IDLE;
            stall_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          stall_q <= 1'b0;
        end
      endcase
    end
  end

  // any slot order, any time outside an operation
  for (genvar g = 0; g < NW; g++) begin : g_buf
    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        buf_q[g] <= `FSPS_ERASED;
      end else if (do_load && pg_word == WORD_BITS'(g)) begin
        buf_q[g] <= data_q;
      end else if (clr_buf) begin
        buf_q[g] <= `FSPS_ERASED;
      end
    end
  end

  // programming only pulls bits low, so reloading a slot cannot restore ones
  always_ff @(posedge clock_in) begin
    if (op_done) begin
      for (int i = 0; i < NW; i++) begin
        if (state_q == ST_ERASE) begin
          flash_q[{page_q, WORD_BITS'(i)}] <= `FSPS_ERASED;
        end else begin
          flash_q[{page_q, WORD_BITS'(i)}] <= flash_q[{page_q, WORD_BITS'(i)}] & buf_q[i];
        end
      end
    end
  end

  // fuse inputs hold stored polarity: zero means programmed
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      load_data_q  <= 8'h00;
      load_valid_q <= 1'b0;
    end else begin
      load_valid_q <= load_op_in;
      if (fuse_rd) begin
        case (ptr_q)
          `FSPS_PTR_FUSE_LO: load_data_q <= fuse_low_in;
          `FSPS_PTR_LOCK:    load_data_q <= {`FSPS_LOCK_PAD, lock_bits_in};
          `FSPS_PTR_FUSE_HI: load_data_q <= fuse_high_in;
          default:           load_data_q <= `FSPS_UNMAPPED;
        endcase
      end else if (load_op_in) begin
        load_data_q <= ptr_q[0] ? rd_word[15:8] : rd_word[7:0];
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign load_data_out  = load_data_q;
  assign load_valid_out = load_valid_q;
  assign stall_out     = stall_q;

  a_erase_start: assert property (@(posedge clock_in) disable iff (rst_in)
    do_erase |=> (state_q == ST_ERASE) && (page_q == $past(pg_page)))
    else $error("erase did not start on its page");

  a_erase_stall: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(stall_out) && (state_q == ST_ERASE) |-> stall_out [*8])
    else $error("stall dropped during erase");

  a_write_stall: assert property (@(posedge clock_in) disable iff (rst_in)
    do_write |=> (stall_out && ctrl_q.en) [*8])
    else $error("stall or enable dropped during write");

  a_load_slot: assert property (@(posedge clock_in) disable iff (rst_in)
    do_load |=> buf_q[$past(pg_word)] == $past(data_q))
    else $error("buffer slot not loaded");

  a_buf_cleared: assert property (@(posedge clock_in) disable iff (rst_in)
    op_done && (state_q == ST_WRITE) |=> (buf_q[0] == `FSPS_ERASED) && !stall_out)
    else $error("buffer not cleared after page write");

  a_eeprom_block: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_wr && eeprom_busy_in && (ctrl_q == '0) |=> ctrl_q == '0)
    else $error("control armed while eeprom busy");

  a_bad_pattern: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_wr && !cmd_ok && (ctrl_q == '0) |=> ctrl_q == '0)
    else $error("illegal pattern took effect");

  a_window_close: assert property (@(posedge clock_in) disable iff (rst_in)
    arm && (cmd == `FSPS_CMD_LOAD) ##1 (!store_op_in && !ctrl_wr) [*4] |=> ctrl_q == '0)
    else $error("enable outlived its four-cycle window");

  a_lock_read: assert property (@(posedge clock_in) disable iff (rst_in)
    fuse_rd && (ptr_q == `FSPS_PTR_LOCK) |=> load_valid_out && (load_data_out[1:0] == $past(lock_bits_in)))
    else $error("lock bits not returned");

  a_fuse_low: assert property (@(posedge clock_in) disable iff (rst_in)
    fuse_rd && (ptr_q == `FSPS_PTR_FUSE_LO) |=> load_data_out == $past(fuse_low_in))
    else $error("fuse low byte not returned");

  a_op_length: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_q != ST_IDLE) |-> (op_cnt_q < 20'(OP_MAX)) && stall_out)
    else $error("operation ran past its longest time");

  // window bookkeeping: a fresh arm always restarts the full store window
  a_window_arm: assert property (@(posedge clock_in) disable iff (rst_in)
    arm |=> win_q == `FSPS_STORE_WIN)
    else $error("store window not restarted");

  a_load_clear: assert property (@(posedge clock_in) disable iff (rst_in)
    do_load && !arm |=> ctrl_q == '0)
    else $error("control not cleared after buffer load");

  // the fuse window is one cycle shorter than the store window
  a_fuse_expire: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl_q.fuse_read && (win_q == LOAD_LAST) && !arm |=> ctrl_q == '0)
    else $error("fuse read bits outlived their window");

  a_ctrl_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    (state_q != ST_IDLE) |-> ctrl_q.en)
    else $error("enable dropped during operation");

  a_idle_release: assert property (@(posedge clock_in) disable iff (rst_in)
    op_done |=> !stall_out && (ctrl_q == '0))
    else $error("stall or control held after operation");

  a_write_page: assert property (@(posedge clock_in) disable iff (rst_in)
    do_write |=> (state_q == ST_WRITE) && (page_q == $past(pg_page)))
    else $error("write did not start on its page");

  // only word zero is sampled, enough to catch a missed erase
  a_erase_fill: assert property (@(posedge clock_in) disable iff (rst_in)
    op_done && (state_q == ST_ERASE) |=> flash_q[{page_q, WORD_BITS'(0)}] == `FSPS_ERASED)
    else $error("page not erased");

  a_clear_cmd: assert property (@(posedge clock_in) disable iff (rst_in)
    arm && (cmd == `FSPS_CMD_CLEAR) && !do_load |=> buf_q[NW-1] == `FSPS_ERASED)
    else $error("buffer not cleared by clear command");

  a_eeprom_wipe: assert property (@(posedge clock_in) disable iff (rst_in)
    eeprom_write_in && !do_load |=> buf_q[0] == `FSPS_ERASED)
    else $error("buffer kept data across eeprom write");

  a_stat_read: assert property (@(posedge clock_in) disable iff (rst_in)
    reg_rd_in && (reg_addr_in == `FSPS_REG_STAT) |=> reg_rdata_out[1] == $past(eeprom_busy_in))
    else $error("status busy bit wrong");

  a_load_valid: assert property (@(posedge clock_in) disable iff (rst_in)
    load_op_in |=> load_valid_out)
    else $error("load answer missing");

  // fuse inputs are levels, so the answer mirrors the previous cycle
  a_fuse_high: assert property (@(posedge clock_in) disable iff (rst_in)
    fuse_rd && (ptr_q == `FSPS_PTR_FUSE_HI) |=> load_data_out == $past(fuse_high_in))
    else $error("fuse high byte not returned");

endmodule // fsps_sequencer

/* File: dv/fsps_cpu_model.sv */
`timescale 1ns/1ps
module fsps_cpu_model (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire logic       load_sel_in,
  input  wire logic [2:0] dly_in,
  output logic            store_op_out,
  output logic            load_op_out
);
  logic       act_q;
  logic       kind_q;
  logic [2:0] cnt_q;
  // pulse is sampled dly_in+3 cycles after the control write: dly 1 is the last legal store slot
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      act_q        <= 1'b0;
      kind_q       <= 1'b0;
      cnt_q        <= 3'h0;
      store_op_out <= 1'b0;
      load_op_out  <= 1'b0;
    end else begin
      store_op_out <= 1'b0;
      load_op_out  <= 1'b0;
      if (req_in) begin
        act_q  <= 1'b1;
        kind_q <= load_sel_in;
        cnt_q  <= dly_in;
      end else if (act_q && cnt_q == 3'h0) begin
        act_q   <= 1'b0;
        store_op_out <= !kind_q;
        load_op_out  <= kind_q;
      end else if (act_q) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule // fsps_cpu_model

/* File: dv/fsps_sequencer_test.sv */
`timescale 1ns/1ps
module fsps_sequencer_test;
  localparam int OP = 20;
  logic        clock_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, ee_busy = 1'b0, ee_wr = 1'b0;
  logic        req = 1'b0, ksel = 1'b0, rd_p = 1'b0, lvalid, stall, store_op, load_op;
  logic [1:0]  addr = 2'h0, lck = 2'h3;
  logic [2:0]  dly = 3'h0;
  logic [7:0]  flo = 8'hFF, fhi = 8'hFF, ldata;
  logic [15:0] wdata = 16'h0000, rdata, d1, d2, d3;
  logic [31:0] rs = 32'h00000062;
  logic [15:0] rq[$];
  logic [7:0]  lq[$];
  int          err_count = 0, n_checks = 0, cyc = 0;

  always #2.5 clock_in = ~clock_in;

  fsps_sequencer #(.OP_CYCLES(OP)) u_dut (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .store_op_in(store_op),
    .load_op_in(load_op),
    .eeprom_busy_in(ee_busy), .eeprom_write_in(ee_wr), .fuse_low_in(flo), .fuse_high_in(fhi),
    .lock_bits_in(lck), .load_data_out(ldata), .load_valid_out(lvalid), .stall_out(stall));
  fsps_cpu_model u_cpu (.clock_in(clock_in), .rst_in(rst_in), .req_in(req), .load_sel_in(ksel),
    .dly_in(dly), .store_op_out(store_op), .load_op_out(load_op));

  function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[15:0];
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    chk({8'h00, g}, {8'h00, e});
  endtask

  // monitor: oldest note is matched against each answer as it appears
  always @(posedge clock_in) begin
    if (rd_p) chk(rdata, rq.pop_front());
    if (lvalid === 1'b1) chk_b(ldata, lq.pop_front());
    rd_p <= rd;
    cyc++;
    if (cyc > 4000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic wr1(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic rd1(input logic [1:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge clock_in);
    addr <= a; rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
  endtask
  task automatic trig(input logic k, input logic [2:0] n);
    req <= 1'b1; ksel <= k; dly <= n;
    @(posedge clock_in);
    req <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  task automatic cmd(input logic [4:0] c, input logic go, input logic k, input logic [2:0] n);
    wr1(2'h0, {11'h000, c});
    if (go) trig(k, n);
  endtask
  task automatic ld(input logic [15:0] p, input logic [15:0] d);
    wr1(2'h1, p); wr1(2'h2, d); cmd(5'h01, 1'b1, 1'b0, 3'h0);
  endtask
  task automatic lr(input logic [15:0] p, input logic [7:0] e);
    wr1(2'h1, p); lq.push_back(e); trig(1'b1, 3'h0);
  endtask
  // stall is counted over a fixed span, so a stuck or short stall both miscount
  task automatic pgop(input logic [15:0] p, input logic [4:0] c);
    int n;
    n = 0;
    wr1(2'h1, p); cmd(c, 1'b1, 1'b0, 3'h1);
    repeat (OP + 20) begin
      @(posedge clock_in);
      if (stall === 1'b1) n++;
    end
    chk(16'(n), 16'(OP));
    rd1(2'h0, 16'h0000);
  endtask

  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    rd1(2'h0, 16'h0000); rd1(2'h3, 16'h0000);
    d1 = rnd(); d2 = rnd();
    flo <= d1[7:0]; fhi <= d1[15:8]; lck <= d2[1:0];
    for (int i = 0; i < 3; i++) begin
      wr1(2'h1, (i == 2) ? 16'h0003 : 16'(i));
      lq.push_back(i == 0 ? d1[7:0] : (i == 1 ? {6'h3F, d2[1:0]} : d1[15:8]));
      cmd(5'h09, 1'b1, 1'b1, 3'h0);
      rd1(2'h0, 16'h0000);
    end
    $display("fuse reads done");
    cmd(5'h01, 1'b0, 1'b0, 3'h0); rd1(2'h0, 16'h0001); rd1(2'h0, 16'h0001); rd1(2'h0, 16'h0000);
    cmd(5'h09, 1'b0, 1'b0, 3'h0); rd1(2'h0, 16'h0009); rd1(2'h0, 16'h0000);
    foreach (d3[i]) if (i < 3) begin
      cmd(i == 0 ? 5'h07 : (i == 1 ? 5'h1F : 5'h02), 1'b0, 1'b0, 3'h0); rd1(2'h0, 16'h0000);
    end
    ee_busy <= 1'b1;
    rd1(2'h3, 16'h0002); cmd(5'h01, 1'b0, 1'b0, 3'h0); rd1(2'h0, 16'h0000);
    ee_busy <= 1'b0;
    $display("window and refusal done");
    d1 = rnd(); d2 = rnd(); d3 = rnd();
    ld(16'h0047, d1); ld(16'h0042, d2);
    rd1(2'h1, 16'h0042); rd1(2'h2, d2);
    pgop(16'h0040, 5'h03); pgop(16'h0040, 5'h05);
    lr(16'h0046, d1[7:0]); lr(16'h0047, d1[15:8]); lr(16'h0042, d2[7:0]);
    lr(16'h0043, d2[15:8]); lr(16'h0044, 8'hFF);
    wr1(2'h1, 16'h0046); cmd(5'h09, 1'b0, 1'b0, 3'h0); ee_busy <= 1'b1; lq.push_back(d1[7:0]);
    trig(1'b1, 3'h0); ee_busy <= 1'b0; rd1(2'h0, 16'h0000);
    pgop(16'h0080, 5'h03); pgop(16'h0080, 5'h05); lr(16'h0082, 8'hFF);
    $display("page one and two done");
    pgop(16'h00C0, 5'h03); ld(16'h00C2, d1);
    @(posedge clock_in); ee_wr <= 1'b1;
    @(posedge clock_in); ee_wr <= 1'b0;
    ld(16'h00C4, d2); cmd(5'h11, 1'b0, 1'b0, 3'h0); ld(16'h00C6, d3); pgop(16'h00C0, 5'h05);
    lr(16'h00C2, 8'hFF); lr(16'h00C4, 8'hFF); lr(16'h00C7, d3[15:8]);
    repeat (4) @(posedge clock_in);
    $display("page three done");
    end_sim();
  end
endmodule // fsps_sequencer_test
